// >>> rtl/ecs_exception_check.sv
// exception check sequencer: picks one vector per check point
// assumes decode, fetch and memory units report faults as levels
// beside the check strobes, synchronous to sys_clk
//
// What this block does
// - nmi beats maskable interrupt at the same boundary.
// - one exception per execution attempt; others appear on retry.
// - faults leave state so the instruction restarts from its start.
// - first check is debug traps from the finished instruction.
// - second check is instruction breakpoint fault on the next one.
// - third check samples nmi and maskable interrupt requests.
// - fourth, fetch segmentation faults give vector 11 or 13.
// - fifth, fetch page faults give vector 14.
// - sixth, decode faults give vector 6 or 13.
// - wait op with task switched and monitor set gives vector 7.
// - coprocessor op with soft float or task switched gives 7.
// - coprocessor op, bar no-wait control forms, then gives 16 on coprocessor error status.
// - per memory reference, segment faults before page faults.
// - checks repeat every instruction, alongside decode and execute.
// - fault while invoking 10 to 13, not a page fault, gives 8.
// - fault while invoking 14, not a page fault, gives 8.
// - numeric operand past its limit gives 13, instruction unexecuted.
// - 16 only from coprocessor or wait ops; addresses latched.
// - reset enters real mode with 16-bit default operands.
// - lock on any form but memory read-modify-write gives 6.
// - lock on repeated string instructions is rejected.
// - lock legality ignores privilege level.
`timescale 1ns/10ps
`default_nettype none
module ecs_exception_check #(
  parameter int unsigned ADDR_W = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // check strobes
  input wire logic bnd_chk,
  input wire logic mem_chk,
  // debug and interrupts
  input wire logic single_step_trap,
  input wire logic data_bkpt_hit,
  input wire logic exec_bkpt_hit,
  input wire logic nmi_req,
  input wire logic maskable_irq_input,
  input wire logic irq_enable_flag,
  input wire logic [7:0] irq_vector,
  // fetch and decode
  input wire logic fetch_seg_fault,
  input wire logic fetch_seg_absent,
  input wire logic fetch_page_fault,
  input wire logic illegal_opcode,
  input wire logic prot_only_op,
  input wire logic [4:0] insn_len,
  input wire logic priv_violation,
  input wire logic lock_prefix,
  input wire logic rep_prefix,
  input wire ecs_pkg::ecs_lock_form_e lock_form,
  input wire logic cs_big_seg,
  // coprocessor
  input wire logic is_wait_op,
  input wire logic is_coproc_op,
  input wire logic coproc_initialise_op,
  input wire logic coproc_clear_exc_op,
  input wire logic coproc_store_status_op,
  input wire logic coproc_store_env_op,
  input wire logic coproc_save_state_op,
  input wire logic fp_unmasked_exc,
  input wire logic [ADDR_W-1:0] fp_iaddr_in,
  input wire logic [ADDR_W-1:0] fp_daddr_in,
  // memory reference
  input wire logic fp_operand_overrun,
  input wire logic mem_seg_fault,
  input wire ecs_pkg::ecs_vec_t mem_seg_vec,
  input wire logic mem_page_fault,
  // handler invocation
  input wire logic inv_fault,
  input wire ecs_pkg::ecs_vec_t inv_fault_vec,
  input wire logic inv_done,
  // exception out
  output logic exc_valid,
  output ecs_pkg::ecs_vec_t exc_vector,
  output logic exc_restart,
  output logic exc_double,
  output logic squash,
  output logic op32_default
);
  import ecs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  ecs_state_e state;
  ecs_state_e next_state;
  logic attempt_faulted;
  logic coproc_err;
  logic [ADDR_W-1:0] fp_iaddr;
  logic [ADDR_W-1:0] fp_daddr;

  wire pe = ctrl[CTRL_PE];
  wire mp = ctrl[CTRL_MP];
  wire em = ctrl[CTRL_EM];
  wire ts = ctrl[CTRL_TS];
  wire v86 = ctrl[CTRL_V86];
  wire running = (state == ECS_RUN);

  // ----------------------------------------------------------------
  // lock legality
  // ----------------------------------------------------------------
  ecs_lock_if lk ();
  assign lk.lock_prefix = lock_prefix;
  assign lk.rep_prefix = rep_prefix;
  assign lk.lock_form = lock_form;

  ecs_lock_check u_lock (
    .lk(lk)
  );

  // ----------------------------------------------------------------
  // boundary checks, in order
  // ----------------------------------------------------------------
  // levels evaluated every cycle, next to decode, not a serial pass
  wire t_trap = single_step_trap || data_bkpt_hit;
  wire t_xbkpt = exec_bkpt_hit;
  wire t_nmi = nmi_req;
  wire t_maskable_irq_input = maskable_irq_input && irq_enable_flag;
  wire t_fseg = fetch_seg_fault;
  wire t_fpage = fetch_page_fault;
  wire pre_dec = t_trap || t_xbkpt || t_nmi || t_maskable_irq_input || t_fseg || t_fpage;
  // protected-only ops are illegal outside plain protected mode
  wire t_badop = illegal_opcode || (prot_only_op && (!pe || v86)) ||
                 lk.lock_bad;
  wire t_decgp = (insn_len > MAX_INSN_BYTES) || (priv_violation && pe);
  wire t_wait7 = is_wait_op && ts && mp;
  wire t_cop7 = is_coproc_op && (em || ts);
  // no-wait control forms never report a pending numeric error
  wire cop_exempt = coproc_initialise_op || coproc_clear_exc_op ||
                    coproc_store_status_op || coproc_store_env_op ||
                    coproc_save_state_op;
  wire t_cerr = coproc_err && (is_wait_op ||
                (is_coproc_op && !cop_exempt));
  wire pre_cop = pre_dec || t_badop || t_decgp;

  // first failing check alone sets the vector
  wire bnd_any = pre_cop || t_wait7 || t_cop7 || t_cerr;
  wire ecs_vec_t fseg_vec = fetch_seg_absent ? VEC_SEG_ABSENT : VEC_GEN_PROT;
  wire ecs_vec_t bnd_vec =
    t_trap ? VEC_DEBUG :
    t_xbkpt ? VEC_DEBUG :
    t_nmi ? VEC_NMI :
    t_maskable_irq_input ? irq_vector :
    t_fseg ? fseg_vec :
    t_fpage ? VEC_PAGE :
    t_badop ? VEC_BAD_OP :
    t_decgp ? VEC_GEN_PROT :
    (t_wait7 || t_cop7) ? VEC_NO_COPROC :
    VEC_COPROC_ERR;
  // traps and interrupts point past the instruction; faults at it
  wire bnd_restart = !(t_trap || (!t_xbkpt && (t_nmi || t_maskable_irq_input)));

  // ----------------------------------------------------------------
  // memory reference checks
  // ----------------------------------------------------------------
  // segmentation sits above paging, so it is checked first
  wire mem_any = fp_operand_overrun || mem_seg_fault || mem_page_fault;
  wire ecs_vec_t mem_vec =
    fp_operand_overrun ? VEC_GEN_PROT :
    mem_seg_fault ? mem_seg_vec :
    VEC_PAGE;

  // ----------------------------------------------------------------
  // selection and escalation
  // ----------------------------------------------------------------
  // later references of a failed attempt are ignored until retry
  wire take_bnd = running && bnd_chk && bnd_any;
  wire take_mem = running && !bnd_chk && mem_chk && !attempt_faulted &&
                  mem_any;
  wire take_inv = !running && inv_fault;
  // a page fault may still be taken while invoking a segment handler
  wire esc_dbl = take_inv && (inv_fault_vec != VEC_PAGE);
  wire take_any = take_bnd || take_mem || take_inv;
  wire ecs_vec_t next_vec =
    esc_dbl ? VEC_DOUBLE :
    take_inv ? inv_fault_vec :
    take_bnd ? bnd_vec :
    mem_vec;
  wire next_restart = take_bnd ? bnd_restart : 1'b1;
  // execution must not retire while a fault is pending this cycle
  assign squash = take_any && next_restart;

  // ----------------------------------------------------------------
  // invocation tracking
  // ----------------------------------------------------------------
  // double fault handler itself is not watched; shutdown is elsewhere
  always_comb begin
    next_state = state;
    unique case (state)
      ECS_RUN: begin
        if (take_any && ecs_is_seg_vec(next_vec)) begin
          next_state = ECS_INV_SEG;
        end else if (take_any && next_vec == VEC_PAGE) begin
          next_state = ECS_INV_PF;
        end
      end
      ECS_INV_SEG, ECS_INV_PF: begin
        if (esc_dbl || inv_done) begin
          next_state = ECS_RUN;
        end else if (take_inv) begin
          next_state = ECS_INV_PF;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ECS_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // exception outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      exc_valid <= 1'b0;
      exc_vector <= 8'h00;
      exc_restart <= 1'b0;
      exc_double <= 1'b0;
    end else begin
      exc_valid <= take_any;
      exc_vector <= take_any ? next_vec : exc_vector;
      exc_restart <= take_any ? next_restart : exc_restart;
      exc_double <= take_any ? esc_dbl : exc_double;
    end
  end

  // one report per attempt; a new boundary check opens a new attempt
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      attempt_faulted <= 1'b0;
    end else if (take_bnd || take_mem) begin
      attempt_faulted <= 1'b1;
    end else if (bnd_chk) begin
      attempt_faulted <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // numeric error status
  // ----------------------------------------------------------------
  // set wins over clear so a fresh error is never dropped
  wire cerr_clear = bnd_chk && (coproc_initialise_op || coproc_clear_exc_op);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      coproc_err <= 1'b0;
      fp_iaddr <= '0;
      fp_daddr <= '0;
    end else if (fp_unmasked_exc) begin
      coproc_err <= 1'b1;
      fp_iaddr <= fp_iaddr_in;
      fp_daddr <= fp_daddr_in;
    end else if (cerr_clear) begin
      coproc_err <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mode and registers
  // ----------------------------------------------------------------
  // reset clears protection enable: real mode, 16-bit operands
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      op32_default <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == REG_CTRL) begin
        ctrl <= reg_wdata[CTRL_W-1:0];
      end
      op32_default <= pe && !v86 && cs_big_seg;
    end
  end

  // read data lives for exactly one cycle; unmapped reads give zero
  wire [31:0] stat_word = {{(32 - STAT_STATE - 3){1'b0}}, state, coproc_err, exc_vector};
  wire [31:0] rd_mux =
    (reg_addr == REG_CTRL) ? {{(32 - CTRL_W){1'b0}}, ctrl} :
    (reg_addr == REG_STATUS) ? stat_word :
    (reg_addr == REG_FP_IADDR) ? 32'(fp_iaddr) :
    (reg_addr == REG_FP_DADDR) ? 32'(fp_daddr) :
    32'h0000_0000;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_nmi_over_maskable_irq_input: assert property (
    (running && bnd_chk && !t_trap && !t_xbkpt && nmi_req && t_maskable_irq_input)
      |=> (exc_valid && exc_vector == VEC_NMI && !exc_restart))
    else $error("nmi did not win over maskable interrupt");

  chk_one_per_try: assert property (
    (running && mem_chk && !bnd_chk && attempt_faulted && !inv_fault) |=> !exc_valid)
    else $error("second exception in one attempt");

  // watched at the source: an interrupt may carry any vector number
  chk_fault_restart: assert property (
    (running && bnd_chk && bnd_any && !t_trap && !t_nmi && !t_maskable_irq_input)
      |=> (exc_valid && exc_restart))
    else $error("fault not marked restartable");

  chk_trap_first: assert property (
    (running && bnd_chk && data_bkpt_hit)
      |=> (exc_valid && exc_vector == VEC_DEBUG && !exc_restart))
    else $error("debug trap not reported first");

  chk_xbkpt_second: assert property (
    (running && bnd_chk && !t_trap && exec_bkpt_hit)
      |=> (exc_vector == VEC_DEBUG && exc_restart))
    else $error("breakpoint fault misreported");

  chk_fetch_seg: assert property (
    (running && bnd_chk && !t_trap && !t_xbkpt && !t_nmi && !t_maskable_irq_input && fetch_seg_fault)
      |=> exc_vector == ($past(fetch_seg_absent) ? VEC_SEG_ABSENT : VEC_GEN_PROT))
    else $error("fetch segment fault vector wrong");

  chk_wait_dev: assert property (
    (running && bnd_chk && !pre_cop && is_wait_op && ts && mp)
      |=> (exc_valid && exc_vector == VEC_NO_COPROC))
    else $error("wait op did not give vector 7");

  chk_mem_order: assert property (
    (running && mem_chk && !bnd_chk && !attempt_faulted && !fp_operand_overrun &&
     mem_seg_fault && mem_page_fault) |=> exc_vector == $past(mem_seg_vec))
    else $error("page fault beat segment fault");

  chk_seg_double: assert property (
    (state == ECS_INV_SEG && inv_fault && inv_fault_vec != VEC_PAGE)
      |=> (exc_valid && exc_double && exc_vector == VEC_DOUBLE) ##1 running)
    else $error("segment invocation fault not escalated");

  chk_pf_twice: assert property (
    (state == ECS_INV_PF && inv_fault && inv_fault_vec == VEC_PAGE && !inv_done)
      |=> (exc_vector == VEC_PAGE && !exc_double && state == ECS_INV_PF))
    else $error("second page fault escalated");

  chk_cerr_exempt: assert property (
    (running && bnd_chk && !pre_dec && cop_exempt && !is_wait_op) |=> exc_vector != VEC_COPROC_ERR
      || !exc_valid)
    else $error("exempt coprocessor form raised 16");

  chk_lock_rep: assert property (
    (running && bnd_chk && !pre_dec && !illegal_opcode && lock_prefix && rep_prefix)
      |=> exc_vector == VEC_BAD_OP)
    else $error("locked repeat string accepted");

  chk_reset_real: assert property (
    $rose(rst_n) |-> (!pe && !op32_default))
    else $error("not in real mode after reset");
endmodule
`default_nettype wire

// >>> rtl/ecs_lock_check.sv
// bus-lock prefix legality check for the decoded instruction
// assumes the decoder classifies the form and flags repeat prefixes
`timescale 1ns/10ps
`default_nettype none
module ecs_lock_check (
  // decoded prefix and form in, verdict out
  ecs_lock_if.chk lk
);
  import ecs_pkg::*;

  // ----------------------------------------------------------------
  // legal forms
  // ----------------------------------------------------------------
  // only memory-destination read-modify-write forms may be locked
  wire form_ok = (lk.lock_form == LF_BIT_MEM) || (lk.lock_form == LF_XCHG_MEM) ||
                 (lk.lock_form == LF_ALU_MEM) || (lk.lock_form == LF_UNARY_MEM);
  // repeats could stall mid-string on a page fault, so never lockable
  wire rep_bad = lk.rep_prefix;
  // no privilege term: lock is usable at any ring
  assign lk.lock_bad = lk.lock_prefix && (rep_bad || !form_ok);
endmodule
`default_nettype wire

// >>> rtl/ecs_lock_if.sv
// carrier between the sequencer and its bus-lock legality checker
// assumes both ends sit in the same clock domain; content is combinational
`timescale 1ns/10ps
`default_nettype none
interface ecs_lock_if;
  import ecs_pkg::*;
  logic lock_prefix;
  logic rep_prefix;
  ecs_lock_form_e lock_form;
  logic lock_bad;
  modport chk (input lock_prefix, input rep_prefix, input lock_form, output lock_bad);
  modport user (output lock_prefix, output rep_prefix, output lock_form, input lock_bad);
endinterface
`default_nettype wire

// >>> rtl/ecs_pkg.sv
// constants, vectors and types for the exception check sequencer
// assumes a 32-bit core; vector numbers are 8 bits wide
package ecs_pkg;
  // ----------------------------------------------------------------
  // exception vectors
  // ----------------------------------------------------------------
  typedef logic [7:0] ecs_vec_t;
  localparam ecs_vec_t VEC_DEBUG = 8'h01;
  localparam ecs_vec_t VEC_NMI = 8'h02;
  localparam ecs_vec_t VEC_BAD_OP = 8'h06;
  localparam ecs_vec_t VEC_NO_COPROC = 8'h07;
  localparam ecs_vec_t VEC_DOUBLE = 8'h08;
  localparam ecs_vec_t VEC_BAD_TSS = 8'h0a;
  localparam ecs_vec_t VEC_SEG_ABSENT = 8'h0b;
  localparam ecs_vec_t VEC_STACK = 8'h0c;
  localparam ecs_vec_t VEC_GEN_PROT = 8'h0d;
  localparam ecs_vec_t VEC_PAGE = 8'h0e;
  localparam ecs_vec_t VEC_COPROC_ERR = 8'h10;
  // longest legal instruction in bytes
  localparam logic [4:0] MAX_INSN_BYTES = 5'h0f;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FP_IADDR = 8'h08;
  localparam logic [7:0] REG_FP_DADDR = 8'h0c;
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned CTRL_PE = 0;
  localparam int unsigned CTRL_MP = 1;
  localparam int unsigned CTRL_EM = 2;
  localparam int unsigned CTRL_TS = 3;
  localparam int unsigned CTRL_V86 = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam int unsigned STAT_CERR = 8;
  localparam int unsigned STAT_STATE = 9;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ECS_RUN = 3'b001,
    ECS_INV_SEG = 3'b010,
    ECS_INV_PF = 3'b100
  } ecs_state_e;

  typedef enum logic [2:0] {
    LF_OTHER = 3'h0,
    LF_BIT_MEM = 3'h1,
    LF_XCHG_MEM = 3'h2,
    LF_ALU_MEM = 3'h3,
    LF_UNARY_MEM = 3'h4
  } ecs_lock_form_e;

  // segment-class vectors that arm the double-fault watch
  function automatic logic ecs_is_seg_vec(input ecs_vec_t v);
    ecs_is_seg_vec = (v == VEC_BAD_TSS) || (v == VEC_SEG_ABSENT) ||
                     (v == VEC_STACK) || (v == VEC_GEN_PROT);
  endfunction
endpackage

// >>> verification/ecs_exception_check_bench.sv
// self-checking bench for the exception check sequencer
// assumes rtl/ is compiled first; the bench drives every design port itself
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module ecs_exception_check_bench;
  import ecs_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, bnd_chk = 1'b0, mem_chk = 1'b0;
  logic single_step_trap = 1'b0, data_bkpt_hit = 1'b0, exec_bkpt_hit = 1'b0;
  logic nmi_req = 1'b0, maskable_irq_input = 1'b0, irq_enable_flag = 1'b0;
  logic [7:0] irq_vector = 8'h00;
  logic fetch_seg_fault = 1'b0, fetch_seg_absent = 1'b0, fetch_page_fault = 1'b0;
  logic illegal_opcode = 1'b0, prot_only_op = 1'b0, priv_violation = 1'b0;
  logic [4:0] insn_len = 5'h00;
  logic lock_prefix = 1'b0, rep_prefix = 1'b0, cs_big_seg = 1'b0;
  ecs_lock_form_e lock_form = LF_OTHER;
  logic is_wait_op = 1'b0, is_coproc_op = 1'b0, fp_unmasked_exc = 1'b0;
  logic [4:0] exempt = 5'h00; // init, clear, store status, store env, save
  logic [31:0] fp_iaddr_in = 32'h0, fp_daddr_in = 32'h0;
  logic fp_operand_overrun = 1'b0, mem_seg_fault = 1'b0, mem_page_fault = 1'b0;
  logic [7:0] mem_seg_vec = 8'h00;
  logic inv_fault = 1'b0, inv_done = 1'b0;
  logic [7:0] inv_fault_vec = 8'h00;
  logic [31:0] reg_rdata;
  logic exc_valid, exc_restart, exc_double, squash, op32_default;
  logic [7:0] exc_vector;
  // bench-side copies of device state, plus seed, stimulus table and tallies
  logic [31:0] seed = 32'h673bad95;
  logic [4:0] ctrl = 5'h00;
  logic cerr = 1'b0;
  logic [31:0] cp_seq [7] = '{32'h8_1000, 32'h10_1000, 32'h20_1000, 32'h2000, 32'h1000,
                              32'h2_1000, 32'h2000};
  int failures = 0, n_tests = 0, cyc = 0;

  ecs_exception_check u_dut (
    .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bnd_chk, .mem_chk,
    .single_step_trap, .data_bkpt_hit, .exec_bkpt_hit, .nmi_req, .maskable_irq_input,
    .irq_enable_flag, .irq_vector, .fetch_seg_fault, .fetch_seg_absent, .fetch_page_fault,
    .illegal_opcode, .prot_only_op, .insn_len, .priv_violation, .lock_prefix, .rep_prefix,
    .lock_form, .cs_big_seg, .is_wait_op, .is_coproc_op, .coproc_initialise_op(exempt[0]),
    .coproc_clear_exc_op(exempt[1]), .coproc_store_status_op(exempt[2]),
    .coproc_store_env_op(exempt[3]), .coproc_save_state_op(exempt[4]), .fp_unmasked_exc,
    .fp_iaddr_in, .fp_daddr_in, .fp_operand_overrun, .mem_seg_fault, .mem_seg_vec,
    .mem_page_fault, .inv_fault, .inv_fault_vec, .inv_done, .exc_valid, .exc_vector,
    .exc_restart, .exc_double, .squash, .op32_default);

  always #12.5 sys_clk = ~sys_clk;
  // hang guard: the planned run needs well under a fifth of this
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // expectation functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] draw();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // {kind, vector}: kind 0 none, 2 trap or interrupt, 3 restartable fault
  function automatic logic [9:0] exp_bnd();
    if (single_step_trap || data_bkpt_hit) return {2'd2, VEC_DEBUG};
    if (exec_bkpt_hit) return {2'd3, VEC_DEBUG};
    if (nmi_req) return {2'd2, VEC_NMI};
    if (maskable_irq_input && irq_enable_flag) return {2'd2, irq_vector};
    if (fetch_seg_fault) return {2'd3, fetch_seg_absent ? VEC_SEG_ABSENT : VEC_GEN_PROT};
    if (fetch_page_fault) return {2'd3, VEC_PAGE};
    if (illegal_opcode || (prot_only_op && (!ctrl[CTRL_PE] || ctrl[CTRL_V86])) ||
        (lock_prefix && (rep_prefix || lock_form == LF_OTHER))) return {2'd3, VEC_BAD_OP};
    if (insn_len > MAX_INSN_BYTES || (priv_violation && ctrl[CTRL_PE])) return {2'd3, VEC_GEN_PROT};
    if ((is_wait_op && ctrl[CTRL_TS] && ctrl[CTRL_MP]) ||
        (is_coproc_op && (ctrl[CTRL_EM] || ctrl[CTRL_TS]))) return {2'd3, VEC_NO_COPROC};
    if (cerr && (is_wait_op || (is_coproc_op && exempt == 5'h00))) return {2'd3, VEC_COPROC_ERR};
    return 10'h000;
  endfunction
  function automatic logic [9:0] exp_mem();
    if (fp_operand_overrun) return {2'd3, VEC_GEN_PROT};
    if (mem_seg_fault) return {2'd3, mem_seg_vec};
    if (mem_page_fault) return {2'd3, VEC_PAGE};
    return 10'h000;
  endfunction
  // a reported 10..14 leaves the device invoking a handler
  function automatic logic armed(input logic [9:0] e);
    return e[9:8] != 2'd0 && e[7:0] >= VEC_BAD_TSS && e[7:0] <= VEC_PAGE;
  endfunction

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", reg_rdata, exp)
  endtask
  // all cause levels at once, so none is assigned twice in a time step
  task automatic drive(input logic [31:0] m, input logic [31:0] r);
    @(posedge sys_clk);
    {single_step_trap, data_bkpt_hit, exec_bkpt_hit, nmi_req, maskable_irq_input} <= m[4:0];
    {fetch_seg_fault, fetch_page_fault, illegal_opcode, prot_only_op, priv_violation} <= m[9:5];
    {lock_prefix, is_wait_op, is_coproc_op, fp_operand_overrun, mem_seg_fault} <= m[14:10];
    mem_page_fault <= m[15];
    insn_len <= m[16] ? 5'h10 : {1'b0, r[3:0]};
    exempt <= m[21:17];
    irq_vector <= r[11:4];
    {irq_enable_flag, fetch_seg_absent, rep_prefix, cs_big_seg} <= r[15:12];
    lock_form <= ecs_lock_form_e'(r[18:16] % 3'd5);
    mem_seg_vec <= 8'h0b + 8'(r[20:19] % 2'd3);
    #1;
  endtask
  task automatic strobe(input logic mem, input logic [9:0] e);
    @(posedge sys_clk);
    if (mem) mem_chk <= 1'b1;
    else bnd_chk <= 1'b1;
    #1;
    `CHK("squash", squash, e[9:8] == 2'd3)
    @(posedge sys_clk);
    bnd_chk <= 1'b0;
    mem_chk <= 1'b0;
    #1;
    `CHK("exc_valid", exc_valid, e[9:8] != 2'd0)
    if (e[9:8] != 2'd0) `CHK("exc_vector", exc_vector, e[7:0])
    if (e[9]) `CHK("exc_restart", exc_restart, e[8])
    if (!mem && (exempt[0] || exempt[1])) cerr = 1'b0;
  endtask
  task automatic invf(input logic [7:0] v, input logic [7:0] ev);
    @(posedge sys_clk);
    inv_fault <= 1'b1;
    inv_fault_vec <= v;
    @(posedge sys_clk);
    inv_fault <= 1'b0;
    #1;
    `CHK("exc_valid", exc_valid, 1'b1)
    `CHK("exc_vector", exc_vector, ev)
    `CHK("exc_double", exc_double, ev == VEC_DOUBLE)
  endtask
  task automatic end_inv();
    @(posedge sys_clk);
    inv_done <= 1'b1;
    @(posedge sys_clk);
    inv_done <= 1'b0;
  endtask
  task automatic wrap_up();
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] ia, da, m;
    logic [9:0] e;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    `CHK("op32_default", op32_default, 1'b0)
    rd_chk(REG_CTRL, 32'h0);
    rd_chk(REG_STATUS, 32'h0000_0200);
    rd_chk(8'h20, 32'h0);
    // numeric error latches both addresses; exempt forms must stay quiet
    ia = draw();
    da = draw();
    @(posedge sys_clk);
    fp_unmasked_exc <= 1'b1;
    fp_iaddr_in <= ia;
    fp_daddr_in <= da;
    @(posedge sys_clk);
    fp_unmasked_exc <= 1'b0;
    cerr = 1'b1;
    rd_chk(REG_FP_IADDR, ia);
    rd_chk(REG_FP_DADDR, da);
    rd_chk(REG_STATUS, 32'h0000_0300);
    foreach (cp_seq[i]) begin
      drive(cp_seq[i], 32'h0);
      strobe(1'b0, exp_bnd());
    end
    drive(32'h3, 32'h8000);
    strobe(1'b0, {2'd2, VEC_NMI});
    // faults met while a handler is being invoked
    drive(32'h400, 32'h8_0000);
    // a clean boundary opens a new attempt, else the reference is ignored
    strobe(1'b0, 10'h000);
    strobe(1'b1, {2'd3, VEC_STACK});
    rd_chk(REG_STATUS, 32'h0000_040c);
    invf(VEC_GEN_PROT, VEC_DOUBLE);
    drive(32'h400, 32'h0);
    strobe(1'b0, 10'h000);
    strobe(1'b1, {2'd3, VEC_SEG_ABSENT});
    invf(VEC_PAGE, VEC_PAGE);
    invf(VEC_BAD_OP, VEC_DOUBLE);
    drive(32'h8000, 32'h0);
    strobe(1'b0, 10'h000);
    strobe(1'b1, {2'd3, VEC_PAGE});
    invf(VEC_PAGE, VEC_PAGE);
    invf(VEC_GEN_PROT, VEC_DOUBLE);
    // sparse random causes so lower-priority checks are reached too
    for (int i = 0; i < 300; i++) begin
      if (i % 16 == 0) begin
        ia = draw();
        ctrl = ia[4:0];
        wr(REG_CTRL, {27'h0, ctrl});
        rd_chk(REG_CTRL, {27'h0, ctrl});
      end
      m = draw() & draw() & draw();
      drive(m, draw());
      e = exp_bnd();
      strobe(1'b0, e);
      `CHK("op32_default", op32_default, ctrl[CTRL_PE] & !ctrl[CTRL_V86] & cs_big_seg)
      if (e[9:8] == 2'd3) begin
        strobe(1'b1, 10'h000);
      end else if (e[9:8] == 2'd0) begin
        e = exp_mem();
        strobe(1'b1, e);
      end
      if (armed(e)) end_inv();
    end
    wrap_up();
  end
endmodule
`default_nettype wire
